// ### rtl/sqpg_pkg.sv
// sqpg_pkg: offsets, field positions, reset values and counts for the switch globals
// assumes byte-wide register access, most significant byte at the lowest address
package sqpg_pkg;

  // byte addresses
  localparam logic [15:0] PTP_NONEVT_ADDR  = 16'h037d;
  localparam logic [15:0] QUEUE_MGMT_BASE  = 16'h0390;
  localparam logic [15:0] PM_FREE_BASE     = 16'h03ac;
  localparam int          WORD_BYTES       = 4;

  // ptp_nonevent_priority_ctrl fields
  localparam int          NONEVT_OVR_BIT   = 7;
  localparam int          NONEVT_PRI_W     = 4;
  localparam logic        NONEVT_OVR_RST   = 1'b0;
  localparam logic [3:0]  NONEVT_PRI_RST   = 4'hf;

  // queue_management_ctrl fields (low byte)
  localparam int          SPLIT_LSB        = 6;
  localparam int          MEMB_DISCARD_BIT = 1;
  localparam logic [1:0]  SPLIT_RST        = 2'h2;
  localparam logic [7:0]  QUEUE_LOW_RST    = 8'h82;

  // two_queue_priority_split codes
  localparam logic [1:0]  SPLIT_ONLY3      = 2'h0;
  localparam logic [1:0]  SPLIT_UNUSED     = 2'h1;
  localparam logic [1:0]  SPLIT_2UP        = 2'h2;
  localparam logic [1:0]  SPLIT_1UP        = 2'h3;

  // packet_memory_free_status fields
  localparam int          FREE_LSB         = 16;
  localparam int          FREE_W           = 11;
  localparam logic [10:0] FREE_MAX         = 11'h3f7;

  localparam int          NUM_PORTS        = 3;

endpackage

// ### rtl/sqpg_free_block_counter.sv
// sqpg_free_block_counter: live count of unused packet-memory blocks
// assumes allocate/release strobes come from the buffer manager on mclk
`timescale 1ns/100ps

module sqpg_free_block_counter #(
  parameter int          CNT_W   = sqpg_pkg::FREE_W,
  parameter logic [10:0] MAX_CNT = sqpg_pkg::FREE_MAX
) (
  // clock and reset
  input  wire logic             mclk,
  input  wire logic             nrst,
  // block events
  input  wire logic             blkAlloc,
  input  wire logic             blkRelease,
  // count
  output logic [CNT_W-1:0]      freeCount_r
);

  logic [CNT_W-1:0] freeCount_nxt;

  // simultaneous alloc and release cancel; saturate at both ends
  always_comb begin
    freeCount_nxt = freeCount_r;
    if (blkAlloc && !blkRelease && freeCount_r != '0) begin
      freeCount_nxt = freeCount_r - CNT_W'(1);
    end else if (blkRelease && !blkAlloc && freeCount_r != CNT_W'(MAX_CNT)) begin
      freeCount_nxt = freeCount_r + CNT_W'(1);
    end
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      freeCount_r <= CNT_W'(MAX_CNT);
    end else begin
      freeCount_r <= freeCount_nxt;
    end
  end

endmodule

// ### rtl/sqpg_switch_globals.sv
// sqpg_switch_globals: ptp non-event priority, two-queue split, vlan membership
// discard and free packet-memory block status, with their byte-wide registers
// assumes all frame-side inputs are produced on mclk by the forwarding pipeline
`timescale 1ns/100ps

module sqpg_switch_globals #(
  parameter int NPORT = sqpg_pkg::NUM_PORTS
) (
  // clock and reset
  input  wire logic             mclk,
  input  wire logic             nrst,
  // register access
  input  wire logic [15:0]      regAddr,
  input  wire logic             regWr,
  input  wire logic             regRd,
  input  wire logic [7:0]       regWdata,
  output logic      [7:0]       regRdata_r,
  output logic                  regRdValid_r,
  // ptp classification
  input  wire logic             clsValid,
  input  wire logic             clsNonEvent,
  input  wire logic [3:0]       clsQosPri,
  output logic      [3:0]       clsPri_r,
  output logic                  clsPriValid_r,
  // two-queue mapping
  input  wire logic             qmapValid,
  input  wire logic [1:0]       qmapPri,
  output logic                  qmapHigh_r,
  output logic                  qmapValid_r,
  // forwarding restriction
  input  wire logic             fwdValid,
  input  wire logic [NPORT-1:0] fwdDest,
  input  wire logic [NPORT-1:0] fwdMember,
  input  wire logic             fwdMirrorOn,
  input  wire logic             fwdMirrored,
  output logic      [NPORT-1:0] fwdPorts_r,
  output logic                  fwdDrop_r,
  output logic                  fwdOutValid_r,
  // packet memory events
  input  wire logic             blkAlloc,
  input  wire logic             blkRelease
);

  ////////////////////////////////////////////////////////////////////////////
  // registers

  logic                 nonEvtOvr_r;
  logic [3:0]           nonEvtPri_r;
  logic [7:0]           queueLow_r;
  logic [1:0]           splitCode;
  logic                 membDiscard;
  logic [10:0]          freeCount;

  assign splitCode   = queueLow_r[sqpg_pkg::SPLIT_LSB +: 2];
  assign membDiscard = queueLow_r[sqpg_pkg::MEMB_DISCARD_BIT];

  // byte map, big-endian within each word:
  //   0x37d      override in 7, priority in 3:0, 6:4 read as zero
  //   0x390-392  read as zero, writes dropped
  //   0x393      split in 7:6, membership discard in 1, reserved storage in 5:2 and 0
  //   0x3ac      free count bits 10:8 in 2:0
  //   0x3ad      free count bits 7:0
  //   0x3ae-3af  read as zero

  // byte within a big-endian word, 3 is bits 7:0
  function automatic logic hitByte(input logic [15:0] a, input logic [15:0] base,
                                   input logic [1:0] lane);
    hitByte = (a == base + 16'(lane));
  endfunction

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      nonEvtOvr_r <= sqpg_pkg::NONEVT_OVR_RST;
      nonEvtPri_r <= sqpg_pkg::NONEVT_PRI_RST;
    end else if (regWr && regAddr == sqpg_pkg::PTP_NONEVT_ADDR) begin
      nonEvtOvr_r <= regWdata[sqpg_pkg::NONEVT_OVR_BIT];
      nonEvtPri_r <= regWdata[sqpg_pkg::NONEVT_PRI_W-1:0];
    end
  end

  // reserved bits 5:2 and 0 are writable storage with no effect
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      queueLow_r <= sqpg_pkg::QUEUE_LOW_RST;
    end else if (regWr && hitByte(regAddr, sqpg_pkg::QUEUE_MGMT_BASE, 2'h3)) begin
      queueLow_r <= regWdata;
    end
  end

  // counter kept apart so its saturation can be reused by the buffer manager;
  // the count has no write path, software only ever sees it
  sqpg_free_block_counter #(
    .CNT_W   (sqpg_pkg::FREE_W),
    .MAX_CNT (sqpg_pkg::FREE_MAX)
  ) uFreeCnt (
    .mclk        (mclk),
    .nrst        (nrst),
    .blkAlloc    (blkAlloc),
    .blkRelease  (blkRelease),
    .freeCount_r (freeCount)
  );

  ////////////////////////////////////////////////////////////////////////////
  // read path, one cycle after the strobe; unmapped bytes read zero

  logic [31:0] freeWord;
  logic [7:0]  rdByte;

  assign freeWord = {5'h00, freeCount, 16'h0000};

  always_comb begin
    rdByte = 8'h00;
    if (regAddr == sqpg_pkg::PTP_NONEVT_ADDR) begin
      rdByte = {nonEvtOvr_r, 3'h0, nonEvtPri_r};
    end else if (hitByte(regAddr, sqpg_pkg::QUEUE_MGMT_BASE, 2'h3)) begin
      rdByte = queueLow_r;
    end else if (hitByte(regAddr, sqpg_pkg::PM_FREE_BASE, 2'h0)) begin
      rdByte = freeWord[31:24];
    end else if (hitByte(regAddr, sqpg_pkg::PM_FREE_BASE, 2'h1)) begin
      rdByte = freeWord[23:16];
    end
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      regRdata_r   <= 8'h00;
      regRdValid_r <= 1'b0;
    end else begin
      regRdValid_r <= regRd;
      if (regRd) begin
        regRdata_r <= rdByte;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // ptp non-event priority
  // event messages are not told apart here: only the non-event flag is steered,
  // everything else keeps the priority the qos classifier already chose

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      clsPri_r      <= 4'h0;
      clsPriValid_r <= 1'b0;
    end else begin
      clsPriValid_r <= clsValid;
      if (clsValid) begin
        if (clsNonEvent && nonEvtOvr_r) begin
          clsPri_r <= nonEvtPri_r;
        end else begin
          clsPri_r <= clsQosPri;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // two-queue split

  logic qHigh;

  // unused code 01 falls back to the reset mapping
  always_comb begin
    case (splitCode)
      sqpg_pkg::SPLIT_ONLY3: qHigh = (qmapPri == 2'h3);
      sqpg_pkg::SPLIT_1UP:   qHigh = (qmapPri != 2'h0);
      default:               qHigh = qmapPri[1];
    endcase
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      qmapHigh_r  <= 1'b0;
      qmapValid_r <= 1'b0;
    end else begin
      qmapValid_r <= qmapValid;
      if (qmapValid) begin
        qmapHigh_r <= qHigh;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // vlan membership restriction

  logic singleDest;

  assign singleDest = ($countones(fwdDest) == 1);

  // mirroring is judged only on the bypass path: a masked frame already stays
  // inside the membership map, so its mirror copy needs no extra drop

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      fwdPorts_r    <= '0;
      fwdDrop_r     <= 1'b0;
      fwdOutValid_r <= 1'b0;
    end else begin
      fwdOutValid_r <= fwdValid;
      if (fwdValid) begin
        if (membDiscard || !singleDest) begin
          fwdPorts_r <= fwdDest & fwdMember;
          fwdDrop_r  <= ((fwdDest & fwdMember) == '0);
        end else if (fwdMirrorOn && fwdMirrored) begin
          fwdPorts_r <= '0;
          fwdDrop_r  <= 1'b1;
        end else begin
          fwdPorts_r <= fwdDest;
          fwdDrop_r  <= 1'b0;
        end
      end
    end
  end

endmodule

// ### verification/sqpg_switch_globals_properties.sv
// sqpg_switch_globals_properties: port-level checks of the switch globals
// assumes one mclk domain, nrst asynchronous active low
`timescale 1ns/100ps

module sqpg_switch_globals_chk #(
  parameter int NPORT = 3
) (
  // clock and reset
  input wire logic             mclk,
  input wire logic             nrst,
  // register access
  input wire logic [15:0]      regAddr,
  input wire logic             regWr,
  input wire logic             regRd,
  input wire logic [7:0]       regWdata,
  input wire logic [7:0]       regRdata_r,
  input wire logic             regRdValid_r,
  // ptp classification
  input wire logic             clsValid,
  input wire logic             clsNonEvent,
  input wire logic [3:0]       clsQosPri,
  input wire logic [3:0]       clsPri_r,
  input wire logic             clsPriValid_r,
  // two-queue mapping
  input wire logic             qmapValid,
  input wire logic [1:0]       qmapPri,
  input wire logic             qmapHigh_r,
  input wire logic             qmapValid_r,
  // forwarding restriction
  input wire logic             fwdValid,
  input wire logic [NPORT-1:0] fwdDest,
  input wire logic [NPORT-1:0] fwdMember,
  input wire logic             fwdMirrorOn,
  input wire logic             fwdMirrored,
  input wire logic [NPORT-1:0] fwdPorts_r,
  input wire logic             fwdDrop_r,
  input wire logic             fwdOutValid_r,
  // packet memory events
  input wire logic             blkAlloc,
  input wire logic             blkRelease
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!nrst);
  ////////////////////////////////////////////////////////////////////////////////
  a_rd_answer: assert property (regRd |=> regRdValid_r) else $error("read not answered");
  a_rd_quiet: assert property (!regRd |=> !regRdValid_r) else $error("stray read pulse");
  a_free_top: assert property (regRd && regAddr == 16'h03ac |=> regRdata_r[7:3] == 5'h0)
    else $error("free count top bits set");
  a_cls_hold: assert property (!clsValid |=> $stable(clsPri_r) && !clsPriValid_r)
    else $error("priority moved idle");
  a_cls_qos_pass: assert property (clsValid && !clsNonEvent |=>
    clsPriValid_r && clsPri_r == $past(clsQosPri)) else $error("qos priority not kept");
  a_qmap_top_high: assert property (qmapValid && qmapPri == 2'h3 |=> qmapHigh_r)
    else $error("priority 3 not high");
  a_qmap_zero_low: assert property (qmapValid && qmapPri == 2'h0 |=>
    qmapValid_r && !qmapHigh_r) else $error("priority 0 not low");
  a_fwd_multi_mask: assert property (fwdValid && $countones(fwdDest) != 1 |=>
    fwdOutValid_r && fwdPorts_r == ($past(fwdDest) & $past(fwdMember)))
    else $error("multi dest not masked");
  a_fwd_in_dest: assert property (fwdValid |=> (fwdPorts_r & ~$past(fwdDest)) == '0)
    else $error("port outside dest");
  a_fwd_drop_empty: assert property (fwdOutValid_r |-> fwdDrop_r == (fwdPorts_r == '0))
    else $error("drop flag wrong");
  c_read: cover property (regRd ##1 regRdValid_r);
  c_cls: cover property (clsValid && clsNonEvent);
  c_drop: cover property (fwdOutValid_r && fwdDrop_r);
endmodule

bind sqpg_switch_globals sqpg_switch_globals_chk #(.NPORT(NPORT)) chk_u (
  .mclk          (mclk),
  .nrst          (nrst),
  .regAddr       (regAddr),
  .regWr         (regWr),
  .regRd         (regRd),
  .regWdata      (regWdata),
  .regRdata_r    (regRdata_r),
  .regRdValid_r  (regRdValid_r),
  .clsValid      (clsValid),
  .clsNonEvent   (clsNonEvent),
  .clsQosPri     (clsQosPri),
  .clsPri_r      (clsPri_r),
  .clsPriValid_r (clsPriValid_r),
  .qmapValid     (qmapValid),
  .qmapPri       (qmapPri),
  .qmapHigh_r    (qmapHigh_r),
  .qmapValid_r   (qmapValid_r),
  .fwdValid      (fwdValid),
  .fwdDest       (fwdDest),
  .fwdMember     (fwdMember),
  .fwdMirrorOn   (fwdMirrorOn),
  .fwdMirrored   (fwdMirrored),
  .fwdPorts_r    (fwdPorts_r),
  .fwdDrop_r     (fwdDrop_r),
  .fwdOutValid_r (fwdOutValid_r),
  .blkAlloc      (blkAlloc),
  .blkRelease    (blkRelease)
);

// ### verification/sqpg_tb.sv
// testbench: directed scenarios for the switch globals block
// assumes byte register strobes and one-cycle registered answers
`timescale 1ns/100ps

module testbench;
  logic        mclk = 0, nrst = 0, regWr = 0, regRd = 0, clsValid = 0, clsNonEvent = 0;
  logic        qmapValid = 0, fwdValid = 0, fwdMirrorOn = 0, fwdMirrored = 0;
  logic        blkAlloc = 0, blkRelease = 0, regRdValid_r, clsPriValid_r, qmapHigh_r;
  logic        qmapValid_r, fwdDrop_r, fwdOutValid_r;
  logic [15:0] regAddr = 0;
  logic [7:0]  regWdata = 0, regRdata_r;
  logic [3:0]  clsQosPri = 0, clsPri_r;
  logic [1:0]  qmapPri = 0;
  logic [2:0]  fwdDest = 0, fwdMember = 0, fwdPorts_r;
  int          n_errors = 0, samples_checked = 0;

  sqpg_switch_globals dut_u (
    .mclk          (mclk),
    .nrst          (nrst),
    .regAddr       (regAddr),
    .regWr         (regWr),
    .regRd         (regRd),
    .regWdata      (regWdata),
    .regRdata_r    (regRdata_r),
    .regRdValid_r  (regRdValid_r),
    .clsValid      (clsValid),
    .clsNonEvent   (clsNonEvent),
    .clsQosPri     (clsQosPri),
    .clsPri_r      (clsPri_r),
    .clsPriValid_r (clsPriValid_r),
    .qmapValid     (qmapValid),
    .qmapPri       (qmapPri),
    .qmapHigh_r    (qmapHigh_r),
    .qmapValid_r   (qmapValid_r),
    .fwdValid      (fwdValid),
    .fwdDest       (fwdDest),
    .fwdMember     (fwdMember),
    .fwdMirrorOn   (fwdMirrorOn),
    .fwdMirrored   (fwdMirrored),
    .fwdPorts_r    (fwdPorts_r),
    .fwdDrop_r     (fwdDrop_r),
    .fwdOutValid_r (fwdOutValid_r),
    .blkAlloc      (blkAlloc),
    .blkRelease    (blkRelease)
  );
  always #2.5 mclk = ~mclk;
  ////////////////////////////////////////////////////////////////////////////////
  task chk(string nm, logic [7:0] e, logic [7:0] g);
    samples_checked++;
    if (g !== e) begin
      n_errors++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask
  task wr(logic [15:0] a, logic [7:0] d);
    @(posedge mclk) {regAddr, regWdata, regWr} <= {a, d, 1'b1};
    @(posedge mclk) regWr <= 0;
  endtask
  task rd(logic [15:0] a, logic [7:0] e);
    @(posedge mclk) {regAddr, regRd} <= {a, 1'b1};
    @(posedge mclk) regRd <= 0;
    #1 chk("regRdata", e, regRdata_r);
    chk("regRdValid", 1, regRdValid_r);
  endtask
  task cls(logic ne, logic [3:0] q, logic [3:0] e);
    @(posedge mclk) {clsValid, clsNonEvent, clsQosPri} <= {1'b1, ne, q};
    @(posedge mclk) clsValid <= 0;
    #1 chk("clsPri", {1'b1, 3'h0, e}, {clsPriValid_r, 3'h0, clsPri_r});
  endtask
  task fwd(logic [2:0] d, logic [2:0] m, logic mir, logic [3:0] e);
    @(posedge mclk) {fwdValid, fwdDest, fwdMember} <= {1'b1, d, m};
    {fwdMirrorOn, fwdMirrored} <= {mir, mir};
    @(posedge mclk) fwdValid <= 0;
    #1 chk("fwdDropPorts", {4'h1, e}, {3'h0, fwdOutValid_r, fwdDrop_r, fwdPorts_r});
  endtask
  task blk(logic a, logic r, int n);
    repeat (n) @(posedge mclk) {blkAlloc, blkRelease} <= {a, r};
    @(posedge mclk) {blkAlloc, blkRelease} <= 2'h0;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  task t_reset;
    rd(16'h037d, 8'h0f);
    rd(16'h0393, 8'h82);
    rd(16'h0390, 8'h00);
    rd(16'h03ac, 8'h03);
    rd(16'h03ad, 8'hf7);
    rd(16'h03b0, 8'h00);
    $display("test reset ended");
  endtask
  task t_ptp;
    cls(1, 4'h2, 4'h2);
    wr(16'h037d, 8'hf5);
    rd(16'h037d, 8'h85);
    cls(1, 4'h2, 4'h5);
    cls(0, 4'h2, 4'h2);
    $display("test ptp ended");
  endtask
  task t_split;
    for (int c = 0; c < 4; c++) begin
      wr(16'h0393, {c[1:0], 6'h02});
      for (int p = 0; p < 4; p++) begin
        @(posedge mclk) {qmapValid, qmapPri} <= {1'b1, p[1:0]};
        @(posedge mclk) qmapValid <= 0;
        #1 chk("qmapHigh", {7'h01, 1'(p >= (c == 0 ? 3 : c == 3 ? 1 : 2))},
               {6'h00, qmapValid_r, qmapHigh_r});
      end
    end
    $display("test split ended");
  endtask
  task t_fwd;
    fwd(3'h1, 3'h6, 0, 4'h8);
    wr(16'h0393, 8'h80);
    fwd(3'h1, 3'h6, 0, 4'h1);
    fwd(3'h1, 3'h6, 1, 4'h8);
    fwd(3'h3, 3'h6, 0, 4'h2);
    $display("test forward ended");
  endtask
  task t_free;
    blk(1, 0, 3);
    rd(16'h03ad, 8'hf4);
    blk(1, 1, 2);
    rd(16'h03ad, 8'hf4);
    blk(0, 1, 5);
    rd(16'h03ad, 8'hf7);
    $display("test free ended");
  endtask
  task t_rerst;
    blk(1, 0, 2);
    @(posedge mclk) nrst <= 0;
    repeat (2) @(posedge mclk);
    nrst <= 1;
    rd(16'h037d, 8'h0f);
    rd(16'h0393, 8'h82);
    rd(16'h03ac, 8'h03);
    rd(16'h03ad, 8'hf7);
    $display("test reset again ended");
  endtask
  task test_done;
    $display("checked %0d errors %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  initial begin
    repeat (6) @(posedge mclk);
    nrst <= 1;
    t_reset;
    t_ptp;
    t_split;
    t_fwd;
    t_free;
    t_rerst;
    test_done;
  end
  // whole run is a little over a hundred cycles
  initial begin
    #20000;
    n_errors++;
    test_done;
  end
endmodule
